// ===== ape_pkg.sv
// Package for the analog power enable register bank
package ape_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [31:0] APE_DAC_AMP_IDX = 32'h0000_0011;
  localparam logic [31:0] APE_FILT_REF_IDX = 32'h0000_0012;
  localparam logic [31:0] APE_DAC_AMP_ADDR = APE_DAC_AMP_IDX << 2;
  localparam logic [31:0] APE_FILT_REF_ADDR = APE_FILT_REF_IDX << 2;

  // Values after reset
  localparam logic [7:0] APE_DAC_AMP_RST = 8'h00;
  localparam logic [7:0] APE_FILT_REF_RST = 8'h00;

  // Implemented bits; the others are fixed at zero
  localparam logic [7:0] APE_DAC_AMP_MASK = 8'hf7;
  localparam logic [7:0] APE_FILT_REF_MASK = 8'h1f;

  // Field positions, first register
  localparam int unsigned APE_CONV4_POS = 7;
  localparam int unsigned APE_CONV3_POS = 6;
  localparam int unsigned APE_CONV2_POS = 5;
  localparam int unsigned APE_CONV1_POS = 4;
  localparam int unsigned APE_AMP3_POS = 2;
  localparam int unsigned APE_AMP2_POS = 1;
  localparam int unsigned APE_AMP1_POS = 0;

  // Field positions, second register
  localparam int unsigned APE_GAIN_POS = 4;
  localparam int unsigned APE_LPF_POS = 3;
  localparam int unsigned APE_HPF_POS = 2;
  localparam int unsigned APE_REG_POS = 1;
  localparam int unsigned APE_TEMP_POS = 0;

  // AHB transfer type
  localparam logic [1:0] APE_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] APE_HTRANS_SEQ = 2'h3;

  // Register selected by the address phase
  typedef enum logic [1:0] {
    APE_SEL_NONE = 2'b00,
    APE_SEL_DAC_AMP = 2'b01,
    APE_SEL_FILT_REF = 2'b10
  } ape_sel_t;

  // Captured address phase
  typedef struct packed {
    logic wr;
    logic rd;
    ape_sel_t sel;
  } ape_aphase_t;

  // Enable lines to the analog functions
  typedef struct packed {
    logic conv4_run;
    logic conv3_run;
    logic conv2_run;
    logic conv1_run;
    logic amplifier3_run;
    logic amplifier2_run;
    logic amplifier1_run;
    logic gain_stage_run;
    logic lowpass_run;
    logic highpass_run;
    logic regulator_ref_run;
    logic thermal_sensor_run;
  } ape_run_t;

endpackage

// ===== ape_regs.sv
// AHB-Lite register bank driving the analog power enable lines
`timescale 1ns/1ns
// How it works
// - First register bits 7..4 enable converter channels 4..1; zero stops them.
// - First register bits 2..0 enable amplifier channels 3..1; zero stops them.
// - Second register bit 4 runs the gain adjustment amplifier.
// - Second register bit 3 runs the low-pass filter.
// - Second register bit 2 runs the high-pass filter.
// - Second register bit 1 runs regulator and reference generator together.
// - Second register bit 0 runs the temperature sensor.
module ape_regs
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Enable lines
  output ape_pkg::ape_run_t run
);

  ape_pkg::ape_aphase_t aph_q;
  ape_pkg::ape_aphase_t aph_d;
  logic [7:0] dac_amp_q;
  logic [7:0] filt_ref_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  function automatic ape_pkg::ape_sel_t decode(input logic [31:0] addr);
    if (addr == ape_pkg::APE_DAC_AMP_ADDR)
      return ape_pkg::APE_SEL_DAC_AMP;
    else if (addr == ape_pkg::APE_FILT_REF_ADDR)
      return ape_pkg::APE_SEL_FILT_REF;
    else
      return ape_pkg::APE_SEL_NONE;
  endfunction

  // Zero wait states; every access completes OKAY, unmapped ones included
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Address phase; hsize is not checked since only whole words are used
  always_comb
  begin
    aph_d = '0;
    if (hsel && hready &&
        (htrans == ape_pkg::APE_HTRANS_NONSEQ || htrans == ape_pkg::APE_HTRANS_SEQ))
    begin
      aph_d.wr = hwrite;
      aph_d.rd = !hwrite;
      aph_d.sel = decode(haddr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      aph_q <= '0;
    else if (hready)
      aph_q <= aph_d;
  end

  // Read data is latched in the address phase so it comes from a flop
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (hsel && hready && !hwrite && htrans[1])
    begin
      case (decode(haddr))
        ape_pkg::APE_SEL_DAC_AMP: rdata_d = {24'h00_0000, dac_amp_q};
        ape_pkg::APE_SEL_FILT_REF: rdata_d = {24'h00_0000, filt_ref_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  // Writes land at the end of the data phase; fixed bits stay zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dac_amp_q <= ape_pkg::APE_DAC_AMP_RST;
    else if (aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_DAC_AMP)
      dac_amp_q <= hwdata[7:0] & ape_pkg::APE_DAC_AMP_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      filt_ref_q <= ape_pkg::APE_FILT_REF_RST;
    else if (aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
      filt_ref_q <= hwdata[7:0] & ape_pkg::APE_FILT_REF_MASK;
  end

  // Enable lines straight from the register flops, glitch free
  assign run.conv4_run = dac_amp_q[ape_pkg::APE_CONV4_POS];
  assign run.conv3_run = dac_amp_q[ape_pkg::APE_CONV3_POS];
  assign run.conv2_run = dac_amp_q[ape_pkg::APE_CONV2_POS];
  assign run.conv1_run = dac_amp_q[ape_pkg::APE_CONV1_POS];
  assign run.amplifier3_run = dac_amp_q[ape_pkg::APE_AMP3_POS];
  assign run.amplifier2_run = dac_amp_q[ape_pkg::APE_AMP2_POS];
  assign run.amplifier1_run = dac_amp_q[ape_pkg::APE_AMP1_POS];
  assign run.gain_stage_run = filt_ref_q[ape_pkg::APE_GAIN_POS];
  assign run.lowpass_run = filt_ref_q[ape_pkg::APE_LPF_POS];
  assign run.highpass_run = filt_ref_q[ape_pkg::APE_HPF_POS];
  // One line feeds both the regulator and the reference generator
  assign run.regulator_ref_run = filt_ref_q[ape_pkg::APE_REG_POS];
  assign run.thermal_sensor_run = filt_ref_q[ape_pkg::APE_TEMP_POS];

  chk_conv_enables: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_DAC_AMP)
      |=> ({run.conv4_run, run.conv3_run, run.conv2_run, run.conv1_run}
           == $past(hwdata[7:4])))
    else $error("Converter enables do not follow the written bits");

  chk_amp_enables: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_DAC_AMP)
      |=> ({run.amplifier3_run, run.amplifier2_run, run.amplifier1_run}
           == $past(hwdata[2:0])))
    else $error("Amplifier enables do not follow the written bits");

  chk_gain_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
      |=> run.gain_stage_run == $past(hwdata[4]))
    else $error("Gain stage enable does not follow bit 4");

  chk_lowpass_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
      |=> run.lowpass_run == $past(hwdata[3]))
    else $error("Low-pass enable does not follow bit 3");

  chk_highpass_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
      |=> run.highpass_run == $past(hwdata[2]))
    else $error("High-pass enable does not follow bit 2");

  chk_regulator_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
      |=> $stable(run.regulator_ref_run))
    else $error("Regulator enable changed without a write");

  chk_thermal_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
      |=> run.thermal_sensor_run == $past(hwdata[0]))
    else $error("Thermal sensor enable does not follow bit 0");

  chk_regulator_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
      |=> run.regulator_ref_run == $past(hwdata[1]))
    else $error("Regulator enable does not follow bit 1");

  // Readback is the register as it stood when the read address phase was taken,
  // so a read right behind a write to the same register returns the old value
  chk_readback_conv: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.rd && aph_q.sel == ape_pkg::APE_SEL_DAC_AMP)
      |-> hrdata[7:4] == $past({run.conv4_run, run.conv3_run, run.conv2_run,
                                run.conv1_run}))
    else $error("Readback of bits 7..4 differs from the converter enables");

  chk_readback_amp: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.rd && aph_q.sel == ape_pkg::APE_SEL_DAC_AMP)
      |-> hrdata[2:0] == $past({run.amplifier3_run, run.amplifier2_run, run.amplifier1_run}))
    else $error("Readback of bits 2..0 differs from the amplifier enables");

  chk_readback_filt: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.rd && aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
      |-> hrdata[4:0] == $past({run.gain_stage_run, run.lowpass_run, run.highpass_run,
                                run.regulator_ref_run, run.thermal_sensor_run}))
    else $error("Readback of the second register differs from its enable lines");

  chk_fixed_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    aph_q.rd |-> (hrdata[3] == 1'b0 || aph_q.sel != ape_pkg::APE_SEL_DAC_AMP)
      && (hrdata[7:5] == 3'h0 || aph_q.sel != ape_pkg::APE_SEL_FILT_REF)
      && hrdata[31:8] == 24'h00_0000)
    else $error("A fixed-zero bit read back as one");

  // Enables hold between writes
  chk_conv_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_DAC_AMP)
      |=> $stable({run.conv4_run, run.conv3_run, run.conv2_run, run.conv1_run}))
    else $error("Converter enables changed without a write");

  chk_amp_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_DAC_AMP)
      |=> $stable({run.amplifier3_run, run.amplifier2_run, run.amplifier1_run}))
    else $error("Amplifier enables changed without a write");

  chk_gain_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
      |=> $stable(run.gain_stage_run))
    else $error("Gain stage enable changed without a write");

  chk_lowpass_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
      |=> $stable(run.lowpass_run))
    else $error("Low-pass enable changed without a write");

  chk_highpass_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
      |=> $stable(run.highpass_run))
    else $error("High-pass enable changed without a write");

  chk_thermal_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
      |=> $stable(run.thermal_sensor_run))
    else $error("Thermal sensor enable changed without a write");

  chk_unmapped_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.wr && aph_q.sel == ape_pkg::APE_SEL_NONE)
      |=> $stable(run))
    else $error("A write to an unmapped address changed the enables");

  chk_unmapped_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (aph_q.rd && aph_q.sel == ape_pkg::APE_SEL_NONE)
      |-> hrdata == 32'h0000_0000)
    else $error("A read of an unmapped address returned nonzero data");

  chk_idle_rdata: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !aph_q.rd
      |-> hrdata == 32'h0000_0000)
    else $error("Read data nonzero outside a read data phase");

  chk_fixed_zero_regs: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (dac_amp_q & ~ape_pkg::APE_DAC_AMP_MASK) == 8'h00
      && (filt_ref_q & ~ape_pkg::APE_FILT_REF_MASK) == 8'h00)
    else $error("A fixed-zero register bit was set");

  // Watched through reset as well, so no disable clause here
  chk_reset_clears: assert property (
    @(posedge hclk)
    !hresetn
      |=> run == 12'h000 && hrdata == 32'h0000_0000)
    else $error("Enables or read data not cleared by reset");

  // Address phase capture
  chk_wr_capture: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans[1] && hwrite)
      |=> aph_q.wr && !aph_q.rd)
    else $error("Write address phase not captured");

  chk_rd_capture: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans[1] && !hwrite)
      |=> aph_q.rd && !aph_q.wr)
    else $error("Read address phase not captured");

  chk_no_transfer: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (hready && !(hsel && htrans[1]))
      |=> !aph_q.wr && !aph_q.rd)
    else $error("Data phase started without a transfer");

  chk_decode_dac: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans[1] && haddr == ape_pkg::APE_DAC_AMP_ADDR)
      |=> aph_q.sel == ape_pkg::APE_SEL_DAC_AMP)
    else $error("First register address not decoded");

  chk_decode_filt: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans[1] && haddr == ape_pkg::APE_FILT_REF_ADDR)
      |=> aph_q.sel == ape_pkg::APE_SEL_FILT_REF)
    else $error("Second register address not decoded");

endmodule

// ===== test_ape_regs.sv
// Self-checking bench for the analog power enable register bank
`timescale 1ns/1ns
`define CHK(nm, got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("unexpected %s expected %h seen %h", nm, exp, got); \
    end \
  end
module test_ape_regs;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  ape_pkg::ape_run_t run;
  wire hready = hreadyout;
  int err_total = 0;
  int compares = 0;
  logic [31:0] rd;
  logic [7:0] v;
  always #25 hclk = ~hclk;
  ape_regs u_ape_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .run(run));
  task automatic report_and_stop();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Sampled mid-cycle, so the value seen is the one standing at the next edge
  task automatic wait_ready();
    int n;
    begin
      n = 0;
      @(negedge hclk);
      while (hready !== 1'b1)
      begin
        n++;
        if (n > 50)
        begin
          err_total++;
          report_and_stop();
        end
        @(negedge hclk);
      end
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= ape_pkg::APE_HTRANS_NONSEQ;
    wait_ready();
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
    `CHK("hresp", hresp, 1'b0)
    `CHK("hreadyout", hreadyout, 1'b1)
    @(posedge hclk);
  endtask
  task automatic check_regs(input logic [7:0] e1, input logic [7:0] e2);
    logic [31:0] r;
    begin
      xfer(1'b0, ape_pkg::APE_DAC_AMP_ADDR, 32'h0, r);
      `CHK("dac_amp_power_enable", r, {24'h0, e1})
      xfer(1'b0, ape_pkg::APE_FILT_REF_ADDR, 32'h0, r);
      `CHK("filter_ref_power_enable", r, {24'h0, e2})
      `CHK("conv_run", run[11:8], e1[7:4])
      `CHK("amplifier_run", run[7:5], e1[2:0])
      `CHK("gain_stage_run", run.gain_stage_run, e2[4])
      `CHK("lowpass_run", run.lowpass_run, e2[3])
      `CHK("highpass_run", run.highpass_run, e2[2])
      `CHK("regulator_ref_run", run.regulator_ref_run, e2[1])
      `CHK("thermal_sensor_run", run.thermal_sensor_run, e2[0])
    end
  endtask
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_regs(8'h00, 8'h00);
    // Walking one against walking zero, upper word bits set to catch leaks
    for (int i = 0; i < 8; i++)
    begin
      v = 8'h01 << i;
      xfer(1'b1, ape_pkg::APE_DAC_AMP_ADDR, {24'hffffff, v}, rd);
      xfer(1'b1, ape_pkg::APE_FILT_REF_ADDR, {24'hffffff, ~v}, rd);
      check_regs(v & 8'hf7, ~v & 8'h1f);
    end
    xfer(1'b1, ape_pkg::APE_DAC_AMP_ADDR, 32'hffffffff, rd);
    xfer(1'b1, ape_pkg::APE_FILT_REF_ADDR, 32'hffffffff, rd);
    check_regs(8'hf7, 8'h1f);
    // Unmapped neighbours must neither answer nor disturb the bank
    xfer(1'b1, 32'h0000004c, 32'h00000000, rd);
    xfer(1'b1, 32'h00000040, 32'h00000000, rd);
    xfer(1'b0, 32'h0000004c, 32'h0, rd);
    `CHK("unmapped read", rd, 32'h0)
    check_regs(8'hf7, 8'h1f);
    // Unused functions cleared by software
    xfer(1'b1, ape_pkg::APE_FILT_REF_ADDR, 32'h00000002, rd);
    check_regs(8'hf7, 8'h02);
    // Reset in mid-run drops every enable at once
    hresetn <= 1'b0;
    @(negedge hclk);
    `CHK("run in reset", run, 12'h000)
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_regs(8'h00, 8'h00);
    report_and_stop();
  end
endmodule
